// ---- shared/gcct_pkg.sv ----
// constants for the gated capture/compare timer
// Summary of operation
// - gated mode counts prescaled clocks toward reload
// - gated count advances only while input active
// - gated input deassertion also raises interrupt
// - reload reached: interrupt, load 0001H, continue
// - output pin toggles on each reload reached, not on capture
// - software start count only for first pass
// - interrupt source select limits gated interrupt
// - capture/compare starts at first selected edge
// - later selected edges copy count to capture
// - capture: interrupt, load 0001H, set flag
// - compare match: interrupt, load 0001H, clear flag
// - interrupt source select limits capture/compare interrupt
// - mode is high bit plus low three bits
// - codes 0000-0011 one-shot, continuous, counter, pwm
// - codes 0100-0111 capture, compare, gated, capture/compare
// - codes 1000-1010 dual pwm, restart, comparator
package gcct_pkg;
   // register offsets
   localparam logic [3:0] OFS_CNT_HI = 4'h0;
   localparam logic [3:0] OFS_CNT_LO = 4'h1;
   localparam logic [3:0] OFS_RLD_HI = 4'h2;
   localparam logic [3:0] OFS_RLD_LO = 4'h3;
   localparam logic [3:0] OFS_CAP_HI = 4'h4;
   localparam logic [3:0] OFS_CAP_LO = 4'h5;
   localparam logic [3:0] OFS_CTL0 = 4'h6;
   localparam logic [3:0] OFS_CTL1 = 4'h7;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_CLEAR = 4'h9;
   localparam logic [3:0] OFS_ENABLE = 4'ha;
   // field positions
   localparam int CTL1_ENABLE = 7;
   localparam int CTL1_POL = 6;
   localparam int CTL1_PRES_LSB = 3;
   localparam int CTL0_MODE_HI = 7;
   localparam int CTL0_SEL_LSB = 5;
   localparam int CTL0_OUT_EN = 1;
   localparam int ST_TIMER = 0;
   localparam int ST_RELOAD = 1;
   localparam int ST_INPUT = 2;
   // reset values and count restart value
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] RLD_RST = 16'h0000;
   localparam logic [15:0] CAP_RST = 16'h0000;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [2:0] ST_RST = 3'h0;
   localparam logic [15:0] CNT_RESTART = 16'h0001;
   // interrupt source select codes
   localparam logic [1:0] SEL_INPUT_ONLY = 2'h2;
   localparam logic [1:0] SEL_RELOAD_ONLY = 2'h3;
   // mode codes
   localparam logic [3:0] MODE_ONE_SHOT = 4'h0;
   localparam logic [3:0] MODE_CONTINUOUS = 4'h1;
   localparam logic [3:0] MODE_COUNTER = 4'h2;
   localparam logic [3:0] MODE_PWM_SINGLE = 4'h3;
   localparam logic [3:0] MODE_CAPTURE = 4'h4;
   localparam logic [3:0] MODE_COMPARE = 4'h5;
   localparam logic [3:0] MODE_GATED = 4'h6;
   localparam logic [3:0] MODE_CAP_CMP = 4'h7;
   localparam logic [3:0] MODE_PWM_DUAL = 4'h8;
   localparam logic [3:0] MODE_CAP_RESTART = 4'h9;
   localparam logic [3:0] MODE_CMP_COUNTER = 4'ha;
endpackage

// ---- core/gcct_timer.sv ----
// gated and capture/compare 16-bit timer with register port
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module gcct_timer
   import gcct_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // timer pins
   input wire logic timer_in,
   output logic timer_out,
   output logic timer_out_oe,
   // interrupt
   output logic irq
);

   logic [15:0] cnt_q;
   logic [15:0] rld_q;
   logic [15:0] cap_q;
   logic [7:0] ctl0_q;
   logic [7:0] ctl1_q;
   logic flag_q;
   logic started_q;
   logic tin_q;
   logic [6:0] pre_q;
   logic [2:0] status_q;
   logic [2:0] status_d;
   logic [2:0] inten_q;
   logic [7:0] rdata_q;
   logic irq_q;
   logic tout_q;

   logic ten, pol, tick, at_rld, active, prev_act, sel_edge;
   logic is_gated, is_cc, g_run, g_rld, g_deas, cap_ev, c_rld;
   logic rld_ev, inp_ev, load1, inc, tmr_int;
   logic wr_cnt_hi, wr_cnt_lo;
   logic [3:0] mode;
   logic [1:0] sel;
   logic [2:0] pres;

   // terminal count of the prescaler for a divide of 2^pres
   function automatic logic [6:0] pre_limit(input logic [2:0] p);
      logic [7:0] full;
      full = (8'h01 << p) - 8'h01;
      return full[6:0];
   endfunction

   // register strobe decode
   function automatic logic hit(input logic [3:0] ofs);
      return reg_wr && reg_addr == ofs;
   endfunction

   assign ten = ctl1_q[CTL1_ENABLE];
   assign pol = ctl1_q[CTL1_POL];
   assign pres = ctl1_q[CTL1_PRES_LSB +: 3];
   assign mode = {ctl0_q[CTL0_MODE_HI], ctl1_q[2:0]};
   assign sel = ctl0_q[CTL0_SEL_LSB +: 2];
   assign wr_cnt_hi = hit(OFS_CNT_HI);
   assign wr_cnt_lo = hit(OFS_CNT_LO);

   // mode decode and events
   always_comb begin
      is_gated = ten && mode == MODE_GATED;
      is_cc = ten && mode == MODE_CAP_CMP;
      tick = ten && pre_q == pre_limit(pres);
      at_rld = cnt_q == rld_q;
      active = pol ? timer_in : !timer_in;
      prev_act = pol ? tin_q : !tin_q;
      sel_edge = pol ? (timer_in && !tin_q) : (!timer_in && tin_q);
      g_run = is_gated && active && tick;
      g_rld = g_run && at_rld;
      g_deas = is_gated && prev_act && !active;
      cap_ev = is_cc && started_q && sel_edge;
      c_rld = is_cc && started_q && !cap_ev && tick && at_rld;
      rld_ev = g_rld || c_rld;
      inp_ev = g_deas || cap_ev;
      load1 = rld_ev || cap_ev;
      inc = (g_run || (is_cc && started_q && tick)) && !load1;
      tmr_int = (rld_ev && sel != SEL_INPUT_ONLY)
         || (inp_ev && sel != SEL_RELOAD_ONLY);
   end

   // prescaler
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pre_q <= 7'h00;
      end else if (clk_en) begin
         if (!ten || tick) begin
            pre_q <= 7'h00;
         end else begin
            pre_q <= pre_q + 7'h01;
         end
      end
   end

   // input history and capture/compare start
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tin_q <= 1'b0;
         started_q <= 1'b0;
      end else if (clk_en) begin
         tin_q <= timer_in;
         if (!is_cc) begin
            started_q <= 1'b0;
         end else if (sel_edge) begin
            started_q <= 1'b1;
         end
      end
   end

   // counter
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_q <= CNT_RST;
      end else if (clk_en) begin
         if (wr_cnt_hi) begin
            cnt_q[15:8] <= reg_wdata;
         end else if (wr_cnt_lo) begin
            cnt_q[7:0] <= reg_wdata;
         end else if (load1) begin
            cnt_q <= CNT_RESTART;
         end else if (inc) begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

   // reload and capture registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rld_q <= RLD_RST;
         cap_q <= CAP_RST;
      end else if (clk_en) begin
         if (hit(OFS_RLD_HI)) begin
            rld_q[15:8] <= reg_wdata;
         end
         if (hit(OFS_RLD_LO)) begin
            rld_q[7:0] <= reg_wdata;
         end
         if (cap_ev) begin
            cap_q <= cnt_q;
         end else if (hit(OFS_CAP_HI)) begin
            cap_q[15:8] <= reg_wdata;
         end else if (hit(OFS_CAP_LO)) begin
            cap_q[7:0] <= reg_wdata;
         end
      end
   end

   // control registers and capture flag
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctl0_q <= CTL_RST;
         ctl1_q <= CTL_RST;
         flag_q <= 1'b0;
      end else if (clk_en) begin
         if (hit(OFS_CTL0)) begin
            ctl0_q <= {reg_wdata[7:1], 1'b0};
         end
         if (hit(OFS_CTL1)) begin
            ctl1_q <= reg_wdata;
         end
         if (cap_ev) begin
            flag_q <= 1'b1;
         end else if (c_rld) begin
            flag_q <= 1'b0;
         end
      end
   end

   // output pin
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tout_q <= 1'b0;
      end else if (clk_en && rld_ev && ctl0_q[CTL0_OUT_EN]) begin
         tout_q <= !tout_q;
      end
   end

   // interrupt status, set wins over clear
   always_comb begin
      status_d = status_q;
      if (hit(OFS_CLEAR)) begin
         status_d = status_d & ~reg_wdata[2:0];
      end
      status_d[ST_TIMER] = status_d[ST_TIMER] | tmr_int;
      status_d[ST_RELOAD] = status_d[ST_RELOAD] | rld_ev;
      status_d[ST_INPUT] = status_d[ST_INPUT] | inp_ev;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         status_q <= ST_RST;
         inten_q <= ST_RST;
         irq_q <= 1'b0;
      end else if (clk_en) begin
         status_q <= status_d;
         if (hit(OFS_ENABLE)) begin
            inten_q <= reg_wdata[2:0];
         end
         irq_q <= |(status_d & (hit(OFS_ENABLE) ? reg_wdata[2:0] : inten_q));
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata_q <= 8'h00;
      end else if (clk_en) begin
         if (!reg_rd) begin
            rdata_q <= 8'h00;
         end else if (reg_addr == OFS_CNT_HI) begin
            rdata_q <= cnt_q[15:8];
         end else if (reg_addr == OFS_CNT_LO) begin
            rdata_q <= cnt_q[7:0];
         end else if (reg_addr == OFS_RLD_HI) begin
            rdata_q <= rld_q[15:8];
         end else if (reg_addr == OFS_RLD_LO) begin
            rdata_q <= rld_q[7:0];
         end else if (reg_addr == OFS_CAP_HI) begin
            rdata_q <= cap_q[15:8];
         end else if (reg_addr == OFS_CAP_LO) begin
            rdata_q <= cap_q[7:0];
         end else if (reg_addr == OFS_CTL0) begin
            rdata_q <= {ctl0_q[7:1], flag_q};
         end else if (reg_addr == OFS_CTL1) begin
            rdata_q <= ctl1_q;
         end else if (reg_addr == OFS_STATUS) begin
            rdata_q <= {5'h00, status_q};
         end else if (reg_addr == OFS_ENABLE) begin
            rdata_q <= {5'h00, inten_q};
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign reg_rdata = rdata_q;
   assign timer_out = tout_q;
   assign timer_out_oe = ctl0_q[CTL0_OUT_EN];
   assign irq = irq_q;

   // checks
   logic no_cwr;
   assign no_cwr = !wr_cnt_hi && !wr_cnt_lo;

   sequence s_capture;
      clk_en && cap_ev && no_cwr;
   endsequence

   sequence s_after_capture;
      cnt_q == CNT_RESTART && flag_q && cap_q == $past(cnt_q);
   endsequence

   AST_GATED_INC: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && g_run && !at_rld && no_cwr |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("gated count did not advance");
   AST_GATED_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && is_gated && !active && no_cwr |=> $stable(cnt_q))
      else $error("gated count moved while input inactive");
   AST_GATED_WRAP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && g_rld && no_cwr |=> cnt_q == CNT_RESTART && status_q[ST_RELOAD])
      else $error("gated wrap did not restart at one");
   AST_DEASSERT_INT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && g_deas && sel != SEL_RELOAD_ONLY |=> status_q[ST_TIMER])
      else $error("deassertion interrupt missing");
   AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && rld_ev && ctl0_q[CTL0_OUT_EN] |=> timer_out != $past(timer_out))
      else $error("output did not toggle on wrap");
   AST_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && is_cc && !started_q && no_cwr |=> $stable(cnt_q))
      else $error("capture/compare counted before first edge");
   AST_CAPTURE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_capture |=> s_after_capture)
      else $error("capture did not store count, restart and flag");
   AST_COMPARE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && c_rld && no_cwr |=> !flag_q && cnt_q == CNT_RESTART)
      else $error("compare match did not restart and clear flag");
   AST_SELECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && inp_ev && !rld_ev && sel == SEL_RELOAD_ONLY && !status_q[ST_TIMER]
      |=> !status_q[ST_TIMER])
      else $error("input event interrupted in reload-only setting");
   AST_DISABLED: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !ten && no_cwr |=> $stable(cnt_q))
      else $error("disabled timer changed count");
   AST_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && tmr_int && inten_q[ST_TIMER] && !hit(OFS_ENABLE) |=> irq)
      else $error("enabled event did not raise irq");
   AST_INPUT_ONLY: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && rld_ev && !inp_ev && sel == SEL_INPUT_ONLY && !status_q[ST_TIMER]
      |=> !status_q[ST_TIMER])
      else $error("reload interrupted in input-only setting");
   AST_IDLE_MODE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && ten && !is_gated && !is_cc && no_cwr |=> $stable(cnt_q))
      else $error("count moved in a mode that does not count here");

endmodule

// ---- test/gcct_gate_src.sv ----
// far-side model driving the gate/capture input pin
`timescale 1ns/100ps
module gcct_gate_src (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // command from bench
   input wire logic want_level,
   input wire logic [3:0] lag,
   // pin
   output logic timer_in
);
   logic [3:0] wait_q;
   // follows the commanded level lag+1 cycles after it changes
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         timer_in <= 1'b0;
         wait_q <= 4'h0;
      end else if (want_level == timer_in) begin
         wait_q <= 4'h0;
      end else if (wait_q >= lag) begin
         timer_in <= want_level;
         wait_q <= 4'h0;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule

// ---- test/tb_gcct_timer.sv ----
// self-checking bench for the gated capture/compare timer
`timescale 1ns/100ps
module tb_gcct_timer;
   import gcct_pkg::*;
   logic ref_clk, sys_rst, clk_en, reg_wr, reg_rd, want_level;
   logic [3:0] reg_addr, lag;
   logic [7:0] reg_wdata, reg_rdata, rv;
   logic timer_in, timer_out, timer_out_oe, irq;
   logic [15:0] v, w;
   int n_fail, samples_checked;
   int tgl = 0;
   int cyc = 0;
   gcct_timer i_gcct_timer (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .timer_in(timer_in), .timer_out(timer_out),
      .timer_out_oe(timer_out_oe), .irq(irq));
   gcct_gate_src i_gcct_gate_src (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .want_level(want_level), .lag(lag), .timer_in(timer_in));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         conclude();
      end
   end
   always @(timer_out) tgl++;
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rng(input logic [15:0] got, input int lo, input int hi);
      samples_checked++;
      if ($isunknown(got) || got < lo || got > hi) begin
         n_fail++;
         $display("ERROR %0t got %h exp %h..%h", $time, got, lo[15:0], hi[15:0]);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic rd16(input logic [3:0] a);
      rd(a);
      v[15:8] = rv;
      rd(a + 4'h1);
      v[7:0] = rv;
   endtask
   task automatic w16(input logic [3:0] a, input logic [15:0] d);
      wr(a, d[15:8]);
      wr(a + 4'h1, d[7:0]);
   endtask
   task automatic pin(input logic l, input int n);
      want_level <= l;
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic s_reset();
      rd(OFS_CTL1);
      chk(rv, CTL_RST);
      rd(OFS_STATUS);
      chk(rv, 8'h00);
      rd(4'hb);
      chk(rv, 8'h00);
      chk(irq, 1'b0);
   endtask
   task automatic s_modes();
      for (int m = 0; m <= 10; m++) begin
         if (m == 6 || m == 7) continue;
         wr(OFS_CTL0, {m[3], 7'h00});
         w16(OFS_CNT_HI, 16'h0005);
         wr(OFS_CTL1, {2'b11, 3'h0, m[2:0]});
         pin(1'b1, 6);
         rd16(OFS_CNT_HI);
         chk(v, 16'h0005);
         pin(1'b0, 2);
         wr(OFS_CTL1, 8'h00);
      end
   endtask
   task automatic s_gated();
      int t0;
      wr(OFS_CTL1, {2'b01, 3'h0, MODE_GATED[2:0]});
      wr(OFS_CTL0, 8'h02);
      w16(OFS_CNT_HI, 16'h0002);
      w16(OFS_RLD_HI, 16'h0003);
      wr(OFS_CLEAR, 8'h07);
      wr(OFS_ENABLE, 8'h07);
      wr(OFS_CTL1, {2'b11, 3'h0, MODE_GATED[2:0]});
      chk(timer_out_oe, 1'b1);
      t0 = tgl;
      pin(1'b1, 31);
      rng(16'(tgl - t0), 9, 11);
      pin(1'b0, 3);
      rd16(OFS_CNT_HI);
      w = v;
      rd16(OFS_CNT_HI);
      chk(v, w);
      rng(w, 1, 3);
      rd(OFS_STATUS);
      chk(rv, 8'h07);
      chk(irq, 1'b1);
      wr(OFS_CLEAR, 8'h07);
      rd(OFS_STATUS);
      chk({rv, irq}, 9'h000);
      wr(OFS_CTL0, {1'b0, SEL_RELOAD_ONLY, 5'h02});
      w16(OFS_RLD_HI, 16'hffff);
      pin(1'b1, 4);
      pin(1'b0, 4);
      rd(OFS_STATUS);
      chk(rv, 8'h04);
      wr(OFS_CLEAR, 8'h07);
      wr(OFS_CTL0, {1'b0, SEL_INPUT_ONLY, 5'h02});
      w16(OFS_RLD_HI, 16'h0003);
      w16(OFS_CNT_HI, 16'h0001);
      pin(1'b1, 8);
      rd(OFS_STATUS);
      chk(rv, 8'h02);
      pin(1'b0, 3);
      rd(OFS_STATUS);
      chk(rv, 8'h07);
      w16(OFS_RLD_HI, 16'hffff);
   endtask
   task automatic s_prescale();
      wr(OFS_CTL1, {2'b01, 3'h2, MODE_GATED[2:0]});
      wr(OFS_CTL0, 8'h00);
      w16(OFS_CNT_HI, 16'h0001);
      pin(1'b1, 10);
      rd16(OFS_CNT_HI);
      chk(v, 16'h0001);
      wr(OFS_CTL1, {2'b11, 3'h2, MODE_GATED[2:0]});
      pin(1'b1, 40);
      pin(1'b0, 3);
      rd16(OFS_CNT_HI);
      rng(v, 10, 12);
   endtask
   task automatic s_capcmp();
      wr(OFS_CTL1, {2'b01, 3'h0, MODE_CAP_CMP[2:0]});
      w16(OFS_CNT_HI, 16'h0001);
      w16(OFS_RLD_HI, 16'hffff);
      wr(OFS_CLEAR, 8'h07);
      wr(OFS_CTL1, {2'b11, 3'h0, MODE_CAP_CMP[2:0]});
      pin(1'b1, 20);
      pin(1'b0, 5);
      pin(1'b1, 3);
      rd16(OFS_CAP_HI);
      rng(v, 22, 28);
      rd(OFS_CTL0);
      chk(rv[0], 1'b1);
      rd(OFS_STATUS);
      chk(rv[2], 1'b1);
      w16(OFS_RLD_HI, 16'h0010);
      pin(1'b1, 25);
      rd(OFS_CTL0);
      chk(rv[0], 1'b0);
      rd(OFS_STATUS);
      chk(rv[1], 1'b1);
   endtask
   initial begin
      {n_fail, samples_checked} = '0;
      {reg_wr, reg_rd, want_level} = '0;
      {reg_addr, lag, reg_wdata} = '0;
      clk_en = 1'b1;
      sys_rst = 1'b1;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      s_reset();
      s_modes();
      s_gated();
      lag <= 4'h3;
      s_prescale();
      s_capcmp();
      conclude();
   end
endmodule
